// ---- rtl/acr_config_reg.sv ----
// converter configuration register with single-shot start and status bit
`default_nettype none
// Overview of operation
// RL1 - start/status bit sits at bit 15 and resets to one.
// RL2 - writing one while powered down launches exactly one conversion.
// RL3 - start writes are taken only while powered down; ignored mid-conversion.
// RL4 - writing zero to the start/status bit changes nothing.
// RL5 - start/status reads zero during a conversion, one otherwise.
// RL6 - after a single conversion the device powers down and status reads one.
// RL7 - mode bit 8: zero continuous, one single-shot or power-down; resets one.
// RL8 - pointer value 01b routes reads and writes to this register; the code routes only writes, rd_data shows this register for any pointer.
// RL9 - rate codes select 128 to 3300 samples per second; 111b is 3300.
module acr_config_reg
  import acr_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [1:0] reg_ptr,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  output logic busy,
  output logic conv_done,
  output logic [2:0] input_pair_select,
  output logic [2:0] gain_range_select,
  output logic cont_mode,
  output logic [2:0] sample_rate_select,
  output logic window_mode,
  output logic alert_polarity,
  output logic alert_latch_enable,
  output logic [1:0] alert_queue_setting
);
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  acr_state_t state_q;
  acr_state_t state_d;
  logic sel_cfg;
  logic start_req;
  logic start_go;
  logic tmr_done;
  logic run;

  assign sel_cfg = (reg_ptr == ACR_PTR_CFG); // [RL8]
  assign start_req = sel_cfg && wr_en && wr_data[ACR_OS_BIT]; // [RL4]
  // a start only counts when powered down and the written mode stays single
  assign start_go = start_req && (state_q == ACR_IDLE) && wr_data[ACR_MODE_BIT]; // [RL2] [RL3]
  assign run = (state_q != ACR_IDLE);

  always_comb
  begin
    cfg_d = cfg_q;
    if (sel_cfg && wr_en)
      cfg_d = (cfg_q & ~ACR_CFG_WMASK) | (wr_data & ACR_CFG_WMASK); // [RL8]
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      cfg_q <= ACR_CFG_RESET; // [RL1] [RL7]
    else
      cfg_q <= cfg_d;
  end

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ACR_IDLE:
      begin
        if (!cfg_d[ACR_MODE_BIT])
          state_d = ACR_CONT; // [RL7]
        else if (start_go)
          state_d = ACR_SINGLE; // [RL2]
      end
      ACR_SINGLE:
      begin
        if (tmr_done)
          state_d = cfg_d[ACR_MODE_BIT] ? ACR_IDLE : ACR_CONT; // [RL6]
      end
      ACR_CONT:
      begin
        if (cfg_d[ACR_MODE_BIT])
          state_d = ACR_IDLE; // [RL7]
      end
      default: state_d = ACR_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      state_q <= ACR_IDLE;
    else
      state_q <= state_d;
  end

  acr_rate_timer u_timer (
    .mclk(mclk),
    .srst(srst),
    .start(start_go),
    .run(run),
    .rate_sel(cfg_q[ACR_DR_LSB +: 3]),
    .done(tmr_done)
  );

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rd_data <= ACR_CFG_RESET;
      busy <= 1'b0;
      conv_done <= 1'b0;
    end
    else
    begin
      rd_data <= {(state_d == ACR_IDLE), cfg_d[14:0]}; // [RL5] [RL6]
      busy <= (state_d != ACR_IDLE);
      conv_done <= tmr_done;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      input_pair_select <= ACR_CFG_RESET[ACR_MUX_LSB +: 3];
      gain_range_select <= ACR_CFG_RESET[ACR_PGA_LSB +: 3];
      cont_mode <= 1'b0;
      sample_rate_select <= ACR_DR_RESET;
      window_mode <= ACR_CFG_RESET[ACR_CMODE_BIT];
      alert_polarity <= ACR_CFG_RESET[ACR_POL_BIT];
      alert_latch_enable <= ACR_CFG_RESET[ACR_LAT_BIT];
      alert_queue_setting <= ACR_CFG_RESET[ACR_QUE_LSB +: 2];
    end
    else
    begin
      input_pair_select <= cfg_d[ACR_MUX_LSB +: 3];
      gain_range_select <= cfg_d[ACR_PGA_LSB +: 3];
      cont_mode <= !cfg_d[ACR_MODE_BIT]; // [RL7]
      sample_rate_select <= cfg_d[ACR_DR_LSB +: 3]; // [RL9]
      window_mode <= cfg_d[ACR_CMODE_BIT];
      alert_polarity <= cfg_d[ACR_POL_BIT];
      alert_latch_enable <= cfg_d[ACR_LAT_BIT];
      alert_queue_setting <= cfg_d[ACR_QUE_LSB +: 2];
    end
  end

  sequence s_start;
    start_go;
  endsequence

  sequence s_busy_low;
    !rd_data[ACR_OS_BIT] && busy;
  endsequence

  sequence s_powered_down;
    rd_data[ACR_OS_BIT] && !busy;
  endsequence

  // helper for the fastest rate: armed by a start at code 111b, counts cycles since
  logic fast_arm_q;
  logic [ACR_CNT_W-1:0] fast_cnt_q;

  always_ff @(posedge mclk)
  begin
    if (srst)
      fast_arm_q <= 1'b0;
    else if (start_go && wr_data[ACR_DR_LSB +: 3] == 3'b111)
      fast_arm_q <= 1'b1;
    else if (conv_done || (sel_cfg && wr_en && wr_data[ACR_DR_LSB +: 3] != 3'b111))
      fast_arm_q <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      fast_cnt_q <= '0;
    else if (start_go)
      fast_cnt_q <= ACR_CNT_W'(1);
    else if (fast_arm_q)
      fast_cnt_q <= fast_cnt_q + ACR_CNT_W'(1);
  end

  chk_reset_value: assert property (@(posedge mclk) // [RL1]
    $past(srst) |-> rd_data == ACR_CFG_RESET && !busy && !conv_done)
    else $error("config not at reset value");
  chk_start_busy: assert property (@(posedge mclk) disable iff (srst) // [RL2]
    s_start |=> s_busy_low)
    else $error("start did not raise busy");
  chk_busy_ignore: assert property (@(posedge mclk) disable iff (srst) // [RL3]
    (state_q == ACR_SINGLE) && start_req && !tmr_done |=> state_q == ACR_SINGLE)
    else $error("start during conversion had an effect");
  chk_zero_noeffect: assert property (@(posedge mclk) disable iff (srst) // [RL4]
    sel_cfg && wr_en && !wr_data[ACR_OS_BIT] && wr_data[ACR_MODE_BIT] && state_q == ACR_IDLE
    |=> state_q == ACR_IDLE)
    else $error("zero start write launched a conversion");
  chk_status_read: assert property (@(posedge mclk) disable iff (srst) // [RL5]
    rd_data[ACR_OS_BIT] == (state_q == ACR_IDLE) && busy == (state_q != ACR_IDLE))
    else $error("status bit disagrees with state");
  chk_single_end: assert property (@(posedge mclk) disable iff (srst) // [RL6]
    state_q == ACR_SINGLE && tmr_done && cfg_d[ACR_MODE_BIT] |=> s_powered_down)
    else $error("single conversion did not power down");
  chk_mode_cont: assert property (@(posedge mclk) disable iff (srst) // [RL7]
    !cfg_d[ACR_MODE_BIT] && state_q != ACR_SINGLE |=> state_q == ACR_CONT && cont_mode)
    else $error("continuous mode not entered");
  chk_mode_stop: assert property (@(posedge mclk) disable iff (srst) // [RL7]
    cfg_d[ACR_MODE_BIT] && state_q == ACR_CONT |=> s_powered_down && !cont_mode)
    else $error("continuous mode not left");
  chk_ptr_route: assert property (@(posedge mclk) disable iff (srst) // [RL8]
    wr_en && !sel_cfg |=> $stable(cfg_q))
    else $error("write to other pointer changed config");
  chk_done_pulse: assert property (@(posedge mclk) disable iff (srst) // [RL2]
    conv_done |=> !conv_done)
    else $error("conversion done held longer than one cycle");
  chk_rate_early: assert property (@(posedge mclk) disable iff (srst) // [RL9]
    fast_arm_q && conv_done |-> fast_cnt_q == ACR_CNT_W'(ACR_CLK_HZ / ACR_SPS_3300 + 1))
    else $error("fastest rate conversion ended at the wrong cycle");
  chk_rate_fast: assert property (@(posedge mclk) disable iff (srst) // [RL9]
    fast_arm_q && fast_cnt_q == ACR_CNT_W'(ACR_CLK_HZ / ACR_SPS_3300 + 1) |-> conv_done)
    else $error("fastest rate conversion did not end in time");
endmodule
`default_nettype wire

// ---- rtl/acr_pkg.sv ----
// package: field layout, reset values and timing of the converter configuration register
`default_nettype none
package acr_pkg;
  localparam logic [1:0] ACR_PTR_CONV = 2'b00;
  localparam logic [1:0] ACR_PTR_CFG = 2'b01;
  localparam logic [1:0] ACR_PTR_LO = 2'b10;
  localparam logic [1:0] ACR_PTR_HI = 2'b11;
  localparam int ACR_OS_BIT = 15;
  localparam int ACR_MUX_LSB = 12;
  localparam int ACR_PGA_LSB = 9;
  localparam int ACR_MODE_BIT = 8;
  localparam int ACR_DR_LSB = 5;
  localparam int ACR_CMODE_BIT = 4;
  localparam int ACR_POL_BIT = 3;
  localparam int ACR_LAT_BIT = 2;
  localparam int ACR_QUE_LSB = 0;
  localparam logic [15:0] ACR_CFG_RESET = 16'h8583;
  localparam logic [15:0] ACR_CFG_WMASK = 16'h7fff;
  localparam int ACR_CLK_HZ = 250_000_000;
  localparam logic [2:0] ACR_DR_RESET = 3'b100;
  // sample rate per rate code, in samples per second (timer length is floor of clk / sps cycles)
  localparam int ACR_SPS_128 = 128;
  localparam int ACR_SPS_250 = 250;
  localparam int ACR_SPS_490 = 490;
  localparam int ACR_SPS_920 = 920;
  localparam int ACR_SPS_1600 = 1600;
  localparam int ACR_SPS_2400 = 2400;
  localparam int ACR_SPS_3300 = 3300;
  localparam int ACR_CNT_W = 21;
  typedef enum logic [1:0] {
    ACR_IDLE = 2'b00,
    ACR_SINGLE = 2'b01,
    ACR_CONT = 2'b10
  } acr_state_t;
endpackage
`default_nettype wire

// ---- rtl/acr_rate_timer.sv ----
// conversion period timer: counts one conversion at the selected sample rate
`default_nettype none
module acr_rate_timer
  import acr_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic start,
  input wire logic run,
  input wire logic [2:0] rate_sel,
  output logic done
);
  logic [ACR_CNT_W-1:0] cnt_q;
  logic [ACR_CNT_W-1:0] len;

  function automatic logic [ACR_CNT_W-1:0] rate_len(input logic [2:0] code);
    int sps;
    sps = ACR_SPS_3300;
    unique case (code)
      3'b000: sps = ACR_SPS_128;
      3'b001: sps = ACR_SPS_250;
      3'b010: sps = ACR_SPS_490;
      3'b011: sps = ACR_SPS_920;
      3'b100: sps = ACR_SPS_1600;
      3'b101: sps = ACR_SPS_2400;
      3'b110: sps = ACR_SPS_3300;
      3'b111: sps = ACR_SPS_3300;
    endcase
    return ACR_CNT_W'(ACR_CLK_HZ / sps);
  endfunction

  assign len = rate_len(rate_sel); // [RL9]

  always_ff @(posedge mclk)
  begin
    if (srst || start || !run)
      cnt_q <= '0;
    else if (cnt_q == len - ACR_CNT_W'(1))
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + ACR_CNT_W'(1);
  end

  assign done = run && !start && (cnt_q == len - ACR_CNT_W'(1));
endmodule
`default_nettype wire

// ---- verification/acr_ctrl_model.sv ----
// bus controller model: sets the register pointer and writes whole words
`default_nettype none
module acr_ctrl_model
  import acr_pkg::*;
(
  input wire logic mclk,
  output logic [1:0] reg_ptr,
  output logic wr_en,
  output logic [15:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    reg_ptr = ACR_PTR_CONV;
    wr_en = 1'b0;
    wr_data = 16'h0000;
  end
  // pointer and word launched at the falling edge, held one cycle
  task automatic put(input logic [1:0] ptr, input logic [15:0] w);
    @(negedge mclk);
    reg_ptr = ptr;
    wr_en = 1'b1;
    wr_data = w;
    @(negedge mclk);
    wr_en = 1'b0;
    wr_data = ~w;
  endtask
endmodule
`default_nettype wire

// ---- verification/adc_config_register_oneshot_tb.sv ----
// testbench: reset values, pointer routing, single-shot and continuous runs
`default_nettype none
module adc_config_register_oneshot_tb
  import acr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PER = ACR_CLK_HZ / ACR_SPS_3300;
  logic mclk, srst, wr_en, busy, conv_done, cont_mode, window_mode, alert_polarity;
  logic alert_latch_enable;
  logic [1:0] reg_ptr, alert_queue_setting;
  logic [2:0] input_pair_select, gain_range_select, sample_rate_select;
  logic [15:0] wr_data, rd_data, flds;
  int n_fail, check_count, n;
  assign flds = {1'b0, input_pair_select, gain_range_select, cont_mode, sample_rate_select,
    window_mode, alert_polarity, alert_latch_enable, alert_queue_setting};
  acr_config_reg u_dut (.mclk(mclk), .srst(srst), .reg_ptr(reg_ptr), .wr_en(wr_en),
    .wr_data(wr_data), .rd_data(rd_data), .busy(busy), .conv_done(conv_done),
    .input_pair_select(input_pair_select), .gain_range_select(gain_range_select),
    .cont_mode(cont_mode), .sample_rate_select(sample_rate_select),
    .window_mode(window_mode), .alert_polarity(alert_polarity),
    .alert_latch_enable(alert_latch_enable), .alert_queue_setting(alert_queue_setting));
  acr_ctrl_model u_ctrl (.mclk(mclk), .reg_ptr(reg_ptr), .wr_en(wr_en), .wr_data(wr_data));
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic settle(input int k);
    repeat (k) @(negedge mclk);
  endtask
  initial
  begin
    repeat (90000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end
  initial
  begin
    n_fail = 0;
    check_count = 0;
    srst = 1'b1;
    settle(2);
    srst = 1'b0;
    check("cfg", rd_data, ACR_CFG_RESET);
    check("fields", flds, 16'h0483);
    u_ctrl.put(ACR_PTR_CONV, 16'h0403);
    settle(1);
    check("cfg", rd_data, 16'h8583);
    check("busy", busy, 1'b0);
    u_ctrl.put(ACR_PTR_CFG, 16'h0583);
    settle(1);
    check("busy", busy, 1'b0);
    check("cfg", rd_data, 16'h8583);
    u_ctrl.put(ACR_PTR_CFG, 16'hfbf9);
    u_ctrl.put(ACR_PTR_CFG, 16'hfbf9);
    check("cfg", rd_data, 16'h7bf9);
    check("fields", flds, 16'h7af9);
    check("busy", busy, 1'b1);
    n = 3;
    while (conv_done !== 1'b1 && n < PER + 10)
    begin
      @(negedge mclk);
      n++;
    end
    check("period", n, PER + 1);
    check("busy", busy, 1'b0);
    check("cfg", rd_data, 16'hfbf9);
    settle(1);
    check("done", conv_done, 1'b0);
    settle(19);
    check("busy", busy, 1'b0);
    u_ctrl.put(ACR_PTR_CFG, 16'h0483);
    settle(2);
    check("busy", busy, 1'b1);
    check("cfg", rd_data, 16'h0483);
    srst = 1'b1;
    settle(2);
    srst = 1'b0;
    check("cfg", rd_data, ACR_CFG_RESET);
    check("busy", busy, 1'b0);
    check("fields", flds, 16'h0483);
    u_ctrl.put(ACR_PTR_CFG, 16'h0483);
    settle(2);
    check("busy", busy, 1'b1);
    check("cfg", rd_data, 16'h0483);
    u_ctrl.put(ACR_PTR_CFG, 16'h0583);
    settle(2);
    check("busy", busy, 1'b0);
    check("cfg", rd_data, 16'h8583);
    give_verdict();
  end
endmodule
`default_nettype wire
